// ==== src/nfc_fifo.sv ====
// Small synchronous FIFO for the program data path
`timescale 1ns/1ps
module nfc_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Streams
	nfc_stream_if.snk in_if,
	nfc_stream_if.src out_if
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
	localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} nfc_fifo_state_t;

	nfc_fifo_state_t s;
	nfc_fifo_state_t next_s;
	logic push;
	logic pop;

	assign in_if.ready = (s.cnt != FULL);
	assign out_if.valid = (s.cnt != '0);
	assign out_if.data = s.mem[s.rp];
	assign push = in_if.valid && in_if.ready;
	assign pop = out_if.valid && out_if.ready;

	always_comb
	begin
		next_s = s;
		if (push)
		begin
			next_s.mem[s.wp] = in_if.data;
			next_s.wp = (s.wp == LAST) ? '0 : s.wp + 1'b1;
		end
		if (pop)
			next_s.rp = (s.rp == LAST) ? '0 : s.rp + 1'b1;
		// Simultaneous push and pop leave the fill level unchanged
		if (push && !pop)
			next_s.cnt = s.cnt + 1'b1;
		else if (pop && !push)
			next_s.cnt = s.cnt - 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
			s <= '0;
		else
			s <= next_s;
	end

endmodule : nfc_fifo

// ==== src/nfc_host.sv ====
// Host sequencer driving an 8-bit asynchronous NAND flash through its pins
`timescale 1ns/1ps
module nfc_host #(
	parameter int FIFO_DEPTH = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Job request
	input wire logic req_valid,
	output logic req_ready,
	input wire nfc_pkg::nfc_op_t req_op,
	input wire logic [nfc_pkg::ADDR_W-1:0] req_addr,
	input wire logic [nfc_pkg::LEN_W-1:0] req_len,
	output logic job_busy,
	output logic job_done,
	// Write protect control
	input wire logic wp_release,
	// Program data
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic [7:0] wr_data,
	// Read data
	output logic rd_valid,
	output logic [7:0] rd_data,
	// Flash pins
	output logic ce_n,
	output logic cle,
	output logic ale,
	output logic we_n,
	output logic read_strobe_n,
	output logic wp_n,
	input wire logic ready_busy,
	input wire logic [7:0] shared_byte_bus_in,
	output logic [7:0] shared_byte_bus_out,
	output logic shared_byte_bus_oe
);
	localparam logic [nfc_pkg::TMR_W-1:0] T_LOW = nfc_pkg::TMR_W'(nfc_pkg::WE_LOW_CYC - 1);
	localparam logic [nfc_pkg::TMR_W-1:0] T_RD = nfc_pkg::TMR_W'(nfc_pkg::READ_ACCESS_CYC - 1);
	localparam logic [nfc_pkg::TMR_W-1:0] T_HOLD = nfc_pkg::TMR_W'(nfc_pkg::HOLD_CYC - 1);
	localparam logic [nfc_pkg::TMR_W-1:0] T_WB = nfc_pkg::TMR_W'(nfc_pkg::WB_CYC - 1);

	typedef enum logic [7:0] {
		ST_IDLE = 8'h01,
		ST_CMD1 = 8'h02,
		ST_ADDR = 8'h04,
		ST_DIN = 8'h08,
		ST_CMD2 = 8'h10,
		ST_WAIT = 8'h20,
		ST_DOUT = 8'h40,
		ST_DONE = 8'h80
	} nfc_state_t;

	typedef struct packed {
		nfc_state_t st;
		nfc_pkg::nfc_job_t job;
		logic [nfc_pkg::ADDR_BYTES-1:0][7:0] abytes;
		logic [2:0] idx;
		logic [nfc_pkg::LEN_W-1:0] len;
		logic [nfc_pkg::LEN_W-1:0] cnt;
		logic [1:0] ph;
		logic [nfc_pkg::TMR_W-1:0] tmr;
		logic plane_open;
		logic ce_n;
		logic cle;
		logic ale;
		logic we_n;
		logic re_n;
		logic wp_n;
		logic [7:0] bus_out;
		logic bus_oe;
		logic rd_valid;
		logic [7:0] rd_data;
		logic done;
	} nfc_host_state_t;

	nfc_host_state_t s;
	nfc_host_state_t next_s;
	nfc_pkg::nfc_job_t req_job;
	logic req_fire;
	logic wr_state;
	logic byte_done;
	logic [7:0] wbyte;
	nfc_state_t after_addr;
	nfc_state_t after_din;

	nfc_stream_if #(.W(8)) wr_in();
	nfc_stream_if #(.W(8)) wr_out();

	nfc_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(clk),
		.resetn(resetn),
		.in_if(wr_in),
		.out_if(wr_out)
	);

	assign wr_in.valid = wr_valid;
	assign wr_in.data = wr_data;
	assign wr_ready = wr_in.ready;
	assign wr_out.ready = (s.st == ST_DIN) && (s.ph == 2'h0);

	assign req_job = nfc_pkg::nfc_decode(req_op);
	// Only reset and status reads while busy; those and the second-plane program between plane halves
	assign req_ready = (s.st == ST_IDLE) && (ready_busy || req_job.busy_ok)
		&& (!s.plane_open || req_job.plane_ok);
	assign req_fire = req_valid && req_ready;
	assign wr_state = (s.st == ST_CMD1) || (s.st == ST_ADDR) || (s.st == ST_DIN)
		|| (s.st == ST_CMD2);
	assign after_din = s.job.has_cmd2 ? ST_CMD2 : ST_WAIT;
	assign after_addr = (s.job.din && s.len != '0) ? ST_DIN : after_din;

	always_comb
	begin
		case (s.st)
			ST_CMD1: wbyte = s.job.cmd1;
			ST_ADDR: wbyte = s.abytes[s.idx];
			ST_DIN: wbyte = wr_out.data;
			default: wbyte = s.job.cmd2;
		endcase
	end

	always_comb
	begin
		next_s = s;
		next_s.rd_valid = 1'b0;
		next_s.done = 1'b0;
		next_s.wp_n = wp_release;
		byte_done = 1'b0;
		// Byte engine: setup, strobe low, hold; data stable across the rise
		if (wr_state)
		begin
			case (s.ph)
				2'h0:
				begin
					if (s.st != ST_DIN || wr_out.valid)
					begin
						next_s.bus_out = wbyte;
						next_s.bus_oe = 1'b1;
						next_s.cle = (s.st == ST_CMD1) || (s.st == ST_CMD2);
						next_s.ale = (s.st == ST_ADDR);
						next_s.ph = 2'h1;
					end
				end
				2'h1:
				begin
					next_s.we_n = 1'b0;
					next_s.tmr = T_LOW;
					next_s.ph = 2'h2;
				end
				2'h2:
				begin
					if (s.tmr == '0)
					begin
						next_s.we_n = 1'b1;
						next_s.tmr = T_HOLD;
						next_s.ph = 2'h3;
					end
					else
						next_s.tmr = s.tmr - 1'b1;
				end
				default:
				begin
					if (s.tmr == '0)
						byte_done = 1'b1;
					else
						next_s.tmr = s.tmr - 1'b1;
				end
			endcase
		end
		else if (s.st == ST_DOUT)
		begin
			case (s.ph)
				2'h0:
				begin
					next_s.re_n = 1'b0;
					next_s.tmr = T_RD;
					next_s.ph = 2'h2;
				end
				2'h2:
				begin
					// Sample only after the access delay has run out
					if (s.tmr == '0)
					begin
						next_s.rd_data = shared_byte_bus_in;
						next_s.rd_valid = 1'b1;
						next_s.re_n = 1'b1;
						next_s.tmr = T_HOLD;
						next_s.ph = 2'h3;
					end
					else
						next_s.tmr = s.tmr - 1'b1;
				end
				default:
				begin
					if (s.tmr == '0)
						byte_done = 1'b1;
					else
						next_s.tmr = s.tmr - 1'b1;
				end
			endcase
		end
		if (byte_done)
		begin
			next_s.ph = 2'h0;
			next_s.cle = 1'b0;
			next_s.ale = 1'b0;
			next_s.bus_oe = 1'b0;
		end
		case (s.st)
			ST_IDLE:
			begin
				if (req_fire)
				begin
					next_s.job = req_job;
					// Column low first, zero padding in cycles two and five
					next_s.abytes[0] = req_addr[7:0];
					next_s.abytes[1] = {4'h0, req_addr[nfc_pkg::COL_W-1:8]};
					next_s.abytes[2] = req_addr[nfc_pkg::PAGE_LSB+7:nfc_pkg::PAGE_LSB];
					next_s.abytes[3] = req_addr[nfc_pkg::PAGE_LSB+15:nfc_pkg::PAGE_LSB+8];
					next_s.abytes[4] = {6'h00, req_addr[nfc_pkg::ADDR_W-1:nfc_pkg::ADDR_W-2]};
					next_s.idx = req_job.afirst;
					// Longer bursts than a page buffer would wrap in the device
					next_s.len = (req_len > nfc_pkg::PAGE_BYTES) ? nfc_pkg::PAGE_BYTES : req_len;
					next_s.cnt = '0;
					next_s.ph = 2'h0;
					next_s.ce_n = 1'b0;
					if (req_op == nfc_pkg::OP_PROG_P1 || req_op == nfc_pkg::OP_CB_PROG_P1)
						next_s.plane_open = 1'b1;
					else if (req_op == nfc_pkg::OP_PROG_P2 || req_op == nfc_pkg::OP_RESET)
						next_s.plane_open = 1'b0;
					next_s.st = ST_CMD1;
				end
			end
			ST_CMD1:
				if (byte_done)
					next_s.st = s.job.has_addr ? ST_ADDR : after_addr;
			ST_ADDR:
			begin
				if (byte_done)
				begin
					if (s.idx == s.job.alast)
						next_s.st = after_addr;
					else
						next_s.idx = s.idx + 1'b1;
				end
			end
			ST_DIN:
			begin
				if (byte_done)
				begin
					next_s.cnt = s.cnt + 1'b1;
					if (s.cnt == s.len - 1'b1)
						next_s.st = after_din;
				end
			end
			ST_CMD2:
				if (byte_done)
					next_s.st = ST_WAIT;
			ST_WAIT:
			begin
				// Ready/busy is only valid some time after the last write strobe
				if (s.tmr != '0)
					next_s.tmr = s.tmr - 1'b1;
				else if (!s.job.waitb || ready_busy)
				begin
					next_s.cnt = '0;
					next_s.st = (s.job.dout && s.len != '0) ? ST_DOUT : ST_DONE;
				end
			end
			ST_DOUT:
			begin
				if (byte_done)
				begin
					next_s.cnt = s.cnt + 1'b1;
					if (s.cnt == s.len - 1'b1)
						next_s.st = ST_DONE;
				end
			end
			ST_DONE:
			begin
				next_s.ce_n = 1'b1;
				next_s.done = 1'b1;
				next_s.st = ST_IDLE;
			end
			default: next_s.st = ST_IDLE;
		endcase
		// Entering the wait always starts the busy settling delay
		if (byte_done && next_s.st == ST_WAIT)
			next_s.tmr = T_WB;
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			s <= '0;
			s.st <= ST_IDLE;
			s.ce_n <= 1'b1;
			s.we_n <= 1'b1;
			s.re_n <= 1'b1;
		end
		else
			s <= next_s;
	end

	assign job_busy = (s.st != ST_IDLE);
	assign job_done = s.done;
	assign rd_valid = s.rd_valid;
	assign rd_data = s.rd_data;
	assign ce_n = s.ce_n;
	assign cle = s.cle;
	assign ale = s.ale;
	assign we_n = s.we_n;
	assign read_strobe_n = s.re_n;
	assign wp_n = s.wp_n;
	assign shared_byte_bus_out = s.bus_out;
	assign shared_byte_bus_oe = s.bus_oe;

	a_cmd_latch_edge: assert property (@(posedge clk) disable iff (!resetn)
		$rose(s.we_n) && s.cle |-> s.bus_oe && !s.ale && !s.ce_n)
		else $error("Command strobe rise without driven command");
	a_addr_latch_edge: assert property (@(posedge clk) disable iff (!resetn)
		$rose(s.we_n) && s.ale |-> s.bus_oe && !s.cle && s.st == ST_ADDR)
		else $error("Address strobe rise outside address phase");
	a_write_strobe_sel: assert property (@(posedge clk) disable iff (!resetn)
		$fell(s.we_n) |-> !s.ce_n && s.re_n && s.bus_oe ##1 s.bus_out == $past(s.bus_out))
		else $error("Write strobe low without select or stable data");
	a_read_sample: assert property (@(posedge clk) disable iff (!resetn)
		s.rd_valid |-> !$past(s.re_n) && !$past(s.bus_oe) && $rose(s.re_n))
		else $error("Read data captured without a read strobe");
	a_addr_pad_low: assert property (@(posedge clk) disable iff (!resetn)
		$rose(s.we_n) && s.ale |->
		(s.idx != 3'h1 || s.bus_out[7:4] == 4'h0) && (s.idx != 3'h4 || s.bus_out[7:2] == 6'h00))
		else $error("Address padding bits not low");
	a_erase_rows: assert property (@(posedge clk) disable iff (!resetn)
		s.ale && s.job.cmd1 == nfc_pkg::CMD_ERASE |-> s.idx >= 3'h2)
		else $error("Column cycle sent during erase");
	a_read_confirm: assert property (@(posedge clk) disable iff (!resetn)
		$rose(s.we_n) && s.st == ST_CMD2 && s.job.cmd1 == nfc_pkg::CMD_READ |->
		s.bus_out == nfc_pkg::CMD_READ_GO || s.bus_out == nfc_pkg::CMD_READ_CB)
		else $error("Bad read confirm code");
	a_prog_confirm: assert property (@(posedge clk) disable iff (!resetn)
		$rose(s.we_n) && s.st == ST_CMD2 && s.job.cmd1[7:4] == 4'h8 |->
		s.bus_out == nfc_pkg::CMD_PROG_GO || s.bus_out == nfc_pkg::CMD_PROG_P1_END)
		else $error("Bad program confirm code");
	a_busy_accept: assert property (@(posedge clk) disable iff (!resetn)
		req_fire && !ready_busy |-> req_op inside {nfc_pkg::OP_RESET, nfc_pkg::OP_STATUS,
		nfc_pkg::OP_STATUS2})
		else $error("Job accepted while device busy");
	a_plane_gap: assert property (@(posedge clk) disable iff (!resetn)
		req_fire && s.plane_open |-> req_op inside {nfc_pkg::OP_RESET, nfc_pkg::OP_STATUS,
		nfc_pkg::OP_STATUS2, nfc_pkg::OP_PROG_P2})
		else $error("Illegal job between plane halves");

endmodule : nfc_host

// ==== src/nfc_pkg.sv ====
// Constants, operation codes and job descriptors for the NAND host sequencer
package nfc_pkg;

	// Clock and bus timing, times in ns
	localparam int CLK_NS = 40;
	localparam int WE_LOW_NS = 12;
	localparam int READ_ACCESS_NS = 20;
	localparam int HOLD_NS = 10;
	localparam int WB_NS = 100;
	localparam int WE_LOW_CYC = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
	localparam int READ_ACCESS_CYC = (READ_ACCESS_NS + CLK_NS - 1) / CLK_NS;
	localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
	localparam int WB_CYC = (WB_NS + CLK_NS - 1) / CLK_NS;
	localparam int TMR_W = 3;

	// Address layout
	localparam int ADDR_W = 30;
	localparam int COL_W = 12;
	localparam int PAGE_LSB = 12;
	localparam int PAGE_W = 6;
	localparam int PLANE_BIT = 18;
	localparam int BLOCK_LSB = 19;
	localparam int BLOCK_W = 11;
	localparam int ADDR_BYTES = 5;
	localparam int ROW_FIRST = 2;
	localparam int LEN_W = 12;
	localparam logic [LEN_W-1:0] PAGE_BYTES = 12'h0840;
	localparam logic [LEN_W-1:0] SPARE_FIRST = 12'h0800;

	// Command codes
	localparam logic [7:0] CMD_READ = 8'h00;
	localparam logic [7:0] CMD_READ_GO = 8'h30;
	localparam logic [7:0] CMD_READ_CB = 8'h35;
	localparam logic [7:0] CMD_PROG = 8'h80;
	localparam logic [7:0] CMD_PROG_P2 = 8'h81;
	localparam logic [7:0] CMD_PROG_GO = 8'h10;
	localparam logic [7:0] CMD_PROG_P1_END = 8'h11;
	localparam logic [7:0] CMD_CB_PROG = 8'h85;
	localparam logic [7:0] CMD_ERASE = 8'h60;
	localparam logic [7:0] CMD_ERASE_GO = 8'hD0;
	localparam logic [7:0] CMD_RAND_OUT = 8'h05;
	localparam logic [7:0] CMD_RAND_OUT_GO = 8'hE0;
	localparam logic [7:0] CMD_RESET = 8'hFF;
	localparam logic [7:0] CMD_STATUS = 8'h70;
	localparam logic [7:0] CMD_STATUS2 = 8'hF1;
	localparam logic [7:0] CMD_READ_ID = 8'h90;

	typedef enum logic [3:0] {
		OP_READ = 4'h0,
		OP_READ_CB = 4'h1,
		OP_PROG = 4'h2,
		OP_PROG_P1 = 4'h3,
		OP_PROG_P2 = 4'h4,
		OP_CB_PROG = 4'h5,
		OP_CB_PROG_P1 = 4'h6,
		OP_ERASE = 4'h7,
		OP_ERASE_P1 = 4'h8,
		OP_RAND_IN = 4'h9,
		OP_RAND_OUT = 4'hA,
		OP_RESET = 4'hB,
		OP_STATUS = 4'hC,
		OP_STATUS2 = 4'hD,
		OP_READ_ID = 4'hE
	} nfc_op_t;

	typedef struct packed {
		logic [7:0] cmd1;
		logic has_addr;
		logic [2:0] afirst;
		logic [2:0] alast;
		logic din;
		logic has_cmd2;
		logic [7:0] cmd2;
		logic waitb;
		logic dout;
		logic busy_ok;
		logic plane_ok;
	} nfc_job_t;

	function automatic nfc_job_t nfc_decode(input nfc_op_t op);
		nfc_job_t j;
		j = '{CMD_READ, 1'b1, 3'h0, 3'h4, 1'b0, 1'b0, CMD_READ_GO, 1'b0, 1'b0, 1'b0, 1'b0};
		case (op)
			OP_READ: {j.has_cmd2, j.waitb, j.dout} = 3'h7;
			OP_READ_CB: {j.has_cmd2, j.cmd2, j.waitb} = {1'b1, CMD_READ_CB, 1'b1};
			OP_PROG, OP_PROG_P1, OP_PROG_P2:
			begin
				j.cmd1 = (op == OP_PROG_P2) ? CMD_PROG_P2 : CMD_PROG;
				j.cmd2 = (op == OP_PROG_P1) ? CMD_PROG_P1_END : CMD_PROG_GO;
				{j.din, j.has_cmd2, j.waitb} = 3'h7;
				j.plane_ok = (op == OP_PROG_P2);
			end
			OP_CB_PROG, OP_CB_PROG_P1:
			begin
				j.cmd1 = CMD_CB_PROG;
				j.cmd2 = (op == OP_CB_PROG_P1) ? CMD_PROG_P1_END : CMD_PROG_GO;
				{j.has_cmd2, j.waitb} = 2'h3;
			end
			OP_ERASE, OP_ERASE_P1:
			begin
				{j.cmd1, j.afirst, j.cmd2} = {CMD_ERASE, 3'h2, CMD_ERASE_GO};
				j.has_cmd2 = (op == OP_ERASE);
				j.waitb = (op == OP_ERASE);
			end
			OP_RAND_IN: {j.cmd1, j.alast, j.din} = {CMD_CB_PROG, 3'h1, 1'b1};
			OP_RAND_OUT:
			begin
				{j.cmd1, j.alast, j.cmd2} = {CMD_RAND_OUT, 3'h1, CMD_RAND_OUT_GO};
				{j.has_cmd2, j.dout} = 2'h3;
			end
			OP_READ_ID: {j.cmd1, j.alast, j.dout} = {CMD_READ_ID, 3'h0, 1'b1};
			OP_RESET: {j.cmd1, j.has_addr, j.waitb, j.busy_ok, j.plane_ok} = {CMD_RESET, 4'hF} ^ 12'h008;
			OP_STATUS, OP_STATUS2:
			begin
				j.cmd1 = (op == OP_STATUS) ? CMD_STATUS : CMD_STATUS2;
				{j.has_addr, j.dout, j.busy_ok, j.plane_ok} = 4'h7;
			end
			default: j.cmd1 = CMD_STATUS;
		endcase
		return j;
	endfunction : nfc_decode

endpackage : nfc_pkg

// ==== src/nfc_stream_if.sv ====
// Valid/ready byte stream carrier between the sequencer and its buffer
`timescale 1ns/1ps
interface nfc_stream_if #(parameter int W = 8);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src(output valid, output data, input ready);
	modport snk(input valid, input data, output ready);
endinterface : nfc_stream_if

// ==== tb/nand_flash_command_address_port_tb.sv ====
// Self-checking bench for the NAND host sequencer
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin \
	$display("[ERR] %s exp %0h got %0h", n, e, s); num_errors++; end end
module nand_flash_command_address_port_tb;
	localparam logic [29:0] ADDR_A = {11'h5a3, 1'b1, 6'h2a, 12'h801};
	localparam logic [29:0] ADDR_B = {11'h5a3, 1'b0, 6'h2a, 12'h801};
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic req_valid = 1'b0;
	nfc_pkg::nfc_op_t req_op = nfc_pkg::OP_STATUS;
	logic [29:0] req_addr = 30'h0000_0000;
	logic [11:0] req_len = 12'h000;
	logic wp_release = 1'b0;
	logic wr_valid = 1'b0;
	logic [7:0] wr_data = 8'h00;
	logic req_ready, job_busy, job_done, wr_ready, rd_valid;
	logic ce_n, cle, ale, we_n, read_strobe_n, wp_n, bus_oe, dq_oe, rb_low;
	logic [7:0] rd_data, bus_out, dq_out, bus_w;
	logic flt = 1'b0;
	logic [9:0] ex[$];
	logic [7:0] rdq[$];
	int num_errors = 0;
	int checks_done = 0;

	initial
	begin
		forever #20 clk = ~clk;
	end
	always @(posedge clk) flt <= ~flt;
	always @(posedge clk) if (rd_valid === 1'b1) rdq.push_back(rd_data);
	// Released bus toggles so a stale byte never passes
	assign bus_w = bus_oe ? bus_out : (dq_oe ? dq_out : {8{flt}});

	nfc_host #(.FIFO_DEPTH(4)) i_dut (.clk(clk), .resetn(resetn),
		.req_valid(req_valid), .req_ready(req_ready), .req_op(req_op),
		.req_addr(req_addr), .req_len(req_len), .job_busy(job_busy),
		.job_done(job_done), .wp_release(wp_release), .wr_valid(wr_valid),
		.wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid),
		.rd_data(rd_data), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
		.read_strobe_n(read_strobe_n), .wp_n(wp_n), .ready_busy(!rb_low),
		.shared_byte_bus_in(bus_w), .shared_byte_bus_out(bus_out),
		.shared_byte_bus_oe(bus_oe));
	nfc_flash_model i_flash (.ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
		.read_strobe_n(read_strobe_n), .wp_n(wp_n), .bus(bus_w),
		.dq_out(dq_out), .dq_oe(dq_oe), .rb_low(rb_low));

	task final_report;
		if (num_errors == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : final_report

	task fail;
		num_errors++;
		final_report();
	endtask : fail

	task add(input logic [9:0] x);
		ex.push_back(x);
	endtask : add

	task addr5(input logic [29:0] a, input int first);
		logic [7:0] b[5];
		b = '{a[7:0], {4'h0, a[11:8]}, a[19:12], a[27:20], {6'h00, a[29:28]}};
		for (int i = first; i < 5; i++)
			add({2'h1, b[i]});
	endtask : addr5

	task chk_log(input string n);
		`CHK(n, ex.size(), i_flash.lg.size())
		foreach (ex[i])
			`CHK(n, ex[i], i_flash.lg[i])
		ex.delete();
		i_flash.lg.delete();
	endtask : chk_log

	task run_job(input nfc_pkg::nfc_op_t op, input logic [29:0] a, input logic [11:0] n);
		int k;
		rdq.delete();
		@(negedge clk);
		req_valid = 1'b1;
		req_op = op;
		req_addr = a;
		req_len = n;
		@(posedge clk);
		for (k = 0; k < 200 && req_ready !== 1'b1; k++) @(posedge clk);
		if (k >= 200) fail();
		@(negedge clk);
		req_valid = 1'b0;
		`CHK("job_busy run", 1'b1, job_busy)
		`CHK("ce_n run", 1'b0, ce_n)
		for (k = 0; k < 20000 && job_done !== 1'b1; k++) @(posedge clk);
		if (k >= 20000) fail();
		@(negedge clk);
		`CHK("job_busy idle", 1'b0, job_busy)
		`CHK("ce_n idle", 1'b1, ce_n)
	endtask : run_job

	task push(input logic [7:0] d);
		int k;
		@(negedge clk);
		wr_valid = 1'b1;
		wr_data = d;
		@(posedge clk);
		for (k = 0; k < 2000 && wr_ready !== 1'b1; k++) @(posedge clk);
		if (k >= 2000) fail();
		@(negedge clk);
		wr_valid = 1'b0;
	endtask : push

	task t_reset;
		`CHK("ce_n", 1'b1, ce_n)
		`CHK("we_n", 1'b1, we_n)
		`CHK("wp_n", 1'b0, wp_n)
		`CHK("bus_oe", 1'b0, bus_oe)
	endtask : t_reset

	task t_status;
		run_job(nfc_pkg::OP_STATUS, ADDR_A, 12'h001);
		add(10'h270);
		chk_log("status log");
		`CHK("status byte", 8'h40, rdq[0])
	endtask : t_status

	// Protected program must leave the erased page intact
	task t_protect;
		fork
			run_job(nfc_pkg::OP_PROG, ADDR_A, 12'h001);
			push(8'h11);
		join
		run_job(nfc_pkg::OP_READ, ADDR_A, 12'h001);
		`CHK("protected data", 8'hff, rdq[0])
		i_flash.lg.delete();
	endtask : t_protect

	task t_program;
		@(negedge clk);
		wp_release = 1'b1;
		repeat (2) @(negedge clk);
		`CHK("wp_n released", 1'b1, wp_n)
		for (int i = 0; i < 4; i++)
			push(8'ha0 + 8'(i));
		`CHK("fifo full", 1'b0, wr_ready)
		fork
			run_job(nfc_pkg::OP_PROG, ADDR_A, 12'h006);
			begin
				push(8'ha4);
				push(8'ha5);
			end
		join
		add(10'h280);
		addr5(ADDR_A, 0);
		for (int i = 0; i < 6; i++)
			add({2'h0, 8'ha0 + 8'(i)});
		add(10'h210);
		chk_log("program log");
		run_job(nfc_pkg::OP_READ, ADDR_A, 12'h006);
		add(10'h200);
		addr5(ADDR_A, 0);
		add(10'h230);
		chk_log("read log");
		for (int i = 0; i < 6; i++)
			`CHK("read data", 8'ha0 + 8'(i), rdq[i])
	endtask : t_program

	task t_planes;
		run_job(nfc_pkg::OP_PROG_P1, ADDR_A, 12'h000);
		@(negedge clk);
		req_valid = 1'b1;
		req_op = nfc_pkg::OP_READ;
		repeat (3)
		begin
			@(posedge clk);
			`CHK("plane gate", 1'b0, req_ready)
		end
		run_job(nfc_pkg::OP_STATUS, ADDR_A, 12'h000);
		run_job(nfc_pkg::OP_PROG_P2, ADDR_B, 12'h000);
		add(10'h280);
		addr5(ADDR_A, 0);
		add(10'h211);
		add(10'h270);
		add(10'h281);
		addr5(ADDR_B, 0);
		add(10'h210);
		chk_log("plane log");
	endtask : t_planes

	task t_erase;
		run_job(nfc_pkg::OP_ERASE_P1, ADDR_A, 12'h000);
		run_job(nfc_pkg::OP_ERASE, ADDR_B, 12'h000);
		add(10'h260);
		addr5(ADDR_A, 2);
		add(10'h260);
		addr5(ADDR_B, 2);
		add(10'h2d0);
		chk_log("erase log");
	endtask : t_erase

	task t_codes;
		nfc_pkg::nfc_op_t ops[8];
		logic [9:0] fst[8];
		logic [9:0] lst[8];
		ops = '{nfc_pkg::OP_READ_CB, nfc_pkg::OP_CB_PROG, nfc_pkg::OP_RAND_IN,
			nfc_pkg::OP_RAND_OUT, nfc_pkg::OP_READ_ID, nfc_pkg::OP_CB_PROG_P1,
			nfc_pkg::OP_STATUS2, nfc_pkg::OP_RESET};
		fst = '{10'h200, 10'h285, 10'h285, 10'h205, 10'h290, 10'h285, 10'h2f1, 10'h2ff};
		lst = '{10'h235, 10'h210, 10'h108, 10'h2e0, 10'h101, 10'h211, 10'h2f1, 10'h2ff};
		for (int i = 0; i < 8; i++)
		begin
			run_job(ops[i], ADDR_A, 12'h000);
			`CHK("first code", fst[i], i_flash.lg[0])
			`CHK("last code", lst[i], i_flash.lg[$])
			i_flash.lg.delete();
		end
	endtask : t_codes

	initial
	begin
		repeat (8) @(posedge clk);
		@(negedge clk);
		t_reset();
		resetn = 1'b1;
		t_status();
		t_protect();
		t_program();
		t_planes();
		t_erase();
		t_codes();
		final_report();
	end
endmodule : nand_flash_command_address_port_tb

// ==== tb/nfc_flash_model.sv ====
// Behavioural flash device answering the host sequencer pins
`timescale 1ns/1ps
module nfc_flash_model #(
	parameter int BUSY_NS = 2000,
	parameter int READ_NS = 20,
	parameter logic [7:0] ID_BYTE = 8'h5c // Arbitrary identity value
) (
	// Control strobes
	input wire logic ce_n,
	input wire logic cle,
	input wire logic ale,
	input wire logic we_n,
	input wire logic read_strobe_n,
	input wire logic wp_n,
	// Shared bus
	input wire logic [7:0] bus,
	output logic [7:0] dq_out,
	output logic dq_oe,
	// Open drain pull-down of ready/busy
	output logic rb_low
);
	logic [9:0] lg[$];
	logic [7:0] arr[0:2111];
	logic [7:0] pbuf[0:2111];
	logic [11:0] col = 12'h000;
	logic [7:0] mode = 8'h00;
	int na = 0;
	int bsy = 0;

	initial
	begin
		dq_out = 8'h00;
		foreach (arr[i])
			arr[i] = 8'hff;
	end

	// Counter, so a reset during busy cannot clear it early
	task go_busy;
		bsy++;
		fork
			#(BUSY_NS) bsy--;
		join_none
	endtask : go_busy

	always @(posedge we_n)
	begin
		if (!ce_n)
		begin
			lg.push_back({cle, ale, bus});
			if (cle)
			begin
				na = 0;
				mode = bus;
				if (bus == 8'h30 || bus == 8'h35)
				begin
					pbuf = arr;
					go_busy();
				end
				if (bus == 8'h10 && wp_n)
					arr = pbuf;
				if (bus == 8'h10 || bus == 8'hd0 || bus == 8'hff)
					go_busy();
			end
			else if (ale)
			begin
				if (na == 0)
					col[7:0] = bus;
				if (na == 1)
					col[11:8] = bus[3:0];
				na++;
			end
			else if (col < 12'h0840)
			begin
				pbuf[col] = bus;
				col++;
			end
		end
	end

	// Complement of the previous byte shown until the access delay runs out
	always @(negedge read_strobe_n)
	begin
		if (!ce_n)
		begin
			dq_out = ~dq_out;
			#(READ_NS);
			if (mode == 8'h70 || mode == 8'hf1)
				dq_out = {wp_n, bsy == 0, 6'h00};
			else if (mode == 8'h90)
				dq_out = ID_BYTE;
			else
				dq_out = pbuf[col];
			col++;
		end
	end

	assign dq_oe = !ce_n && !read_strobe_n;
	assign rb_low = (bsy != 0);
endmodule : nfc_flash_model
